// File: ocm_map.svh
// register map, field positions and reset values for the on-chip memory controller
`ifndef OCM_MAP_SVH
`define OCM_MAP_SVH
// ----------------------------------------------------------------
// register bus low-bit selects
// ----------------------------------------------------------------
`define OCM_SEL_INIT 2'h0
`define OCM_SEL_FILL 2'h1
`define OCM_SEL_RANGE 2'h2
`define OCM_SEL_CTRL 2'h3
// ----------------------------------------------------------------
// control register fields (bit 0 is lsb here)
// ----------------------------------------------------------------
`define OCM_CTL_EN 7
`define OCM_CTL_BUSY 5
`define OCM_CTL_FWD 4
`define OCM_CTL_MODE_LO 0
`define OCM_CTL_MODE_HI 2
// ----------------------------------------------------------------
// address geometry
// ----------------------------------------------------------------
`define OCM_RANGE_HI 31
`define OCM_RANGE_LO 24
`define OCM_IADDR_HI 23
`define OCM_IADDR_LO 3
`define OCM_DADDR_HI 23
`define OCM_DADDR_LO 2
`define OCM_FILL_RST 32'h0000_0000
`define OCM_INIT_RST 21'h00_0000
`define OCM_ACCESS_CYCLES 3'h3
`endif

// File: ocm_pkg.sv
// types shared by the on-chip memory controller
package ocm_pkg;
  typedef enum logic [1:0] {OCM_IDLE, OCM_WAIT, OCM_ACCESS, OCM_DONE} ocm_state_t;
endpackage : ocm_pkg

// File: ocm_access_seq.sv
// per-side access sequencer with wait-state divider
`timescale 1ns/10ps
`include "ocm_map.svh"
module ocm_access_seq (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_req,
  input wire logic [2:0] i_mode,
  output logic o_launch,
  output logic o_done
);
  ocm_pkg::ocm_state_t state_r;
  ocm_pkg::ocm_state_t state_nxt;
  logic [2:0] wait_r;
  logic [2:0] wait_nxt;
  logic [1:0] step_r;
  logic [1:0] step_nxt;
  wire multi = (i_mode != 3'h0);
  // ----------------------------------------------------------------
  // sequence: idle, wait states, ram access, data latched
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    wait_nxt = wait_r;
    step_nxt = step_r;
    case (state_r)
      ocm_pkg::OCM_IDLE: begin
        if (i_req) begin
          wait_nxt = i_mode;
          step_nxt = 2'h0;
          state_nxt = multi ? ocm_pkg::OCM_WAIT : ocm_pkg::OCM_ACCESS;
        end
      end
      ocm_pkg::OCM_WAIT: begin
        // wait states before the ram access in multi-cycle mode
        if (wait_r == 3'h0) state_nxt = ocm_pkg::OCM_ACCESS;
        else wait_nxt = wait_r - 3'h1;
      end
      ocm_pkg::OCM_ACCESS: begin
        step_nxt = step_r + 2'h1;
        if (step_r == 2'h1) state_nxt = ocm_pkg::OCM_DONE;
      end
      ocm_pkg::OCM_DONE: state_nxt = ocm_pkg::OCM_IDLE;
      default: state_nxt = ocm_pkg::OCM_IDLE;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_r <= ocm_pkg::OCM_IDLE;
      wait_r <= 3'h0;
      step_r <= 2'h0;
      o_launch <= 1'b0;
      o_done <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wait_r <= wait_nxt;
      step_r <= step_nxt;
      o_launch <= (state_nxt == ocm_pkg::OCM_ACCESS) && (step_nxt == 2'h0);
      o_done <= (state_nxt == ocm_pkg::OCM_DONE);
    end
  end
  property p_four_cycles;
    @(posedge i_clk) disable iff (i_reset)
      (state_r == ocm_pkg::OCM_IDLE && i_req && !multi) |-> ##3 o_done;
  endproperty
  a_four_cycles: assert property (p_four_cycles) else $error("access not four cycles");
  property p_mode_waits;
    @(posedge i_clk) disable iff (i_reset)
      (state_r == ocm_pkg::OCM_IDLE && i_req && multi) |=> !o_launch;
  endproperty
  a_mode_waits: assert property (p_mode_waits) else $error("no wait state");
endmodule : ocm_access_seq

// File: ocm_ctrl.sv
// instruction-side and data-side on-chip memory controller top
`timescale 1ns/10ps
`include "ocm_map.svh"
module ocm_ctrl (
  input wire logic i_clk,
  input wire logic i_reset,
  // tie-offs
  input wire logic [7:0] i_data_regbus_base_tie,
  input wire logic [7:0] i_instr_regbus_base_tie,
  input wire logic [7:0] i_data_range_init_tie,
  input wire logic [7:0] i_data_control_init_tie,
  input wire logic [7:0] i_instr_range_init_tie,
  input wire logic [7:0] i_instr_control_init_tie,
  // register bus
  input wire logic [9:0] i_reg_addr,
  input wire logic i_reg_read,
  input wire logic i_reg_write,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_ack,
  // instruction fetch port
  input wire logic [31:0] i_fetch_addr,
  input wire logic i_fetch_req,
  output logic o_fetch_claim,
  output logic o_fetch_valid,
  output logic [63:0] o_fetch_data,
  // data port
  input wire logic [31:0] i_data_addr,
  input wire logic i_load_req,
  input wire logic i_store_req,
  output logic o_data_claim,
  output logic o_data_is_load,
  output logic o_data_valid,
  output logic [1:0] o_load_use_latency,
  output logic [21:0] o_data_ram_addr,
  output logic o_data_side_flag_out,
  // instruction block ram
  input wire logic [63:0] i_instr_ram_read_data,
  output logic [20:0] o_instr_ram_read_addr,
  output logic o_instr_ram_read_en,
  output logic [20:0] o_instr_ram_write_addr,
  output logic [31:0] o_instr_ram_write_data,
  output logic o_odd_word_write_en,
  output logic o_even_word_write_en
);
  logic [7:0] data_range_compare_r;
  logic [7:0] data_side_control_r;
  logic [7:0] instr_range_compare_r;
  logic [7:0] instr_side_control_r;
  logic [20:0] instr_init_address_r;
  logic [31:0] instr_fill_data_r;
  logic reset_d_r;
  logic ilaunch;
  logic idone;
  logic dlaunch;
  logic ddone;
  logic dload_r;
  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  wire dhit = (i_reg_addr[9:2] == i_data_regbus_base_tie);
  wire ihit = (i_reg_addr[9:2] == i_instr_regbus_base_tie);
  wire [1:0] sel = i_reg_addr[1:0];
  wire wr_drange = i_reg_write && dhit && sel == `OCM_SEL_RANGE;
  wire wr_dctrl = i_reg_write && dhit && sel == `OCM_SEL_CTRL;
  wire wr_init = i_reg_write && ihit && sel == `OCM_SEL_INIT;
  wire wr_fill = i_reg_write && ihit && sel == `OCM_SEL_FILL;
  wire wr_irange = i_reg_write && ihit && sel == `OCM_SEL_RANGE;
  wire wr_ictrl = i_reg_write && ihit && sel == `OCM_SEL_CTRL;
  // data side has only the upper two selects; lower ones read zero
  wire [31:0] drd = (sel == `OCM_SEL_RANGE) ? {24'h00_0000, data_range_compare_r}
    : (sel == `OCM_SEL_CTRL) ? {24'h00_0000, data_side_control_r} : 32'h0000_0000;
  wire [31:0] ird = (sel == `OCM_SEL_INIT) ? {11'h000, instr_init_address_r}
    : (sel == `OCM_SEL_FILL) ? instr_fill_data_r
    : (sel == `OCM_SEL_RANGE) ? {24'h00_0000, instr_range_compare_r}
    : {24'h00_0000, instr_side_control_r};
  wire [31:0] rd_mux = ihit ? ird : dhit ? drd : 32'h0000_0000;
  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire ien = instr_side_control_r[`OCM_CTL_EN];
  wire den = data_side_control_r[`OCM_CTL_EN];
  wire ifetch_hit = ien && i_fetch_req &&
    (i_fetch_addr[`OCM_RANGE_HI:`OCM_RANGE_LO] == instr_range_compare_r);
  wire dreq = i_load_req || i_store_req;
  wire ddec_hit = den && dreq &&
    (i_data_addr[`OCM_RANGE_HI:`OCM_RANGE_LO] == data_range_compare_r);
  wire [2:0] imode = instr_side_control_r[`OCM_CTL_MODE_HI:`OCM_CTL_MODE_LO];
  wire [2:0] dmode = data_side_control_r[`OCM_CTL_MODE_HI:`OCM_CTL_MODE_LO];
  ocm_access_seq u_iseq (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_req(ifetch_hit),
    .i_mode(imode),
    .o_launch(ilaunch),
    .o_done(idone)
  );
  ocm_access_seq u_dseq (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_req(ddec_hit),
    .i_mode(dmode),
    .o_launch(dlaunch),
    .o_done(ddone)
  );
  // ----------------------------------------------------------------
  // registers; reset, and release-edge reload of range and control registers from tie-offs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    reset_d_r <= i_reset;
    if (i_reset) begin
      data_range_compare_r <= 8'h00;
      data_side_control_r <= 8'h00;
      instr_range_compare_r <= 8'h00;
      instr_side_control_r <= 8'h00;
    end else if (reset_d_r) begin
      data_range_compare_r <= i_data_range_init_tie;
      data_side_control_r <= i_data_control_init_tie;
      instr_range_compare_r <= i_instr_range_init_tie;
      instr_side_control_r <= i_instr_control_init_tie;
    end else begin
      if (wr_drange) data_range_compare_r <= i_reg_wdata[7:0];
      if (wr_dctrl) data_side_control_r <= i_reg_wdata[7:0];
      if (wr_irange) instr_range_compare_r <= i_reg_wdata[7:0];
      if (wr_ictrl) instr_side_control_r <= i_reg_wdata[7:0];
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      instr_init_address_r <= `OCM_INIT_RST;
      instr_fill_data_r <= `OCM_FILL_RST;
    end else begin
      if (wr_init) instr_init_address_r <= i_reg_wdata[20:0];
      else if (wr_fill) instr_init_address_r <= instr_init_address_r + 21'h1;
      if (wr_fill) instr_fill_data_r <= i_reg_wdata;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_reg_rdata <= 32'h0000_0000;
      o_reg_ack <= 1'b0;
      o_instr_ram_write_addr <= `OCM_INIT_RST;
      o_instr_ram_write_data <= `OCM_FILL_RST;
      o_odd_word_write_en <= 1'b0;
      o_even_word_write_en <= 1'b0;
      o_instr_ram_read_addr <= 21'h00_0000;
      o_instr_ram_read_en <= 1'b0;
      o_fetch_claim <= 1'b0;
      o_fetch_valid <= 1'b0;
      o_fetch_data <= 64'h0000_0000_0000_0000;
      o_data_claim <= 1'b0;
      o_data_is_load <= 1'b0;
      o_data_valid <= 1'b0;
      o_data_ram_addr <= 22'h00_0000;
      o_load_use_latency <= 2'h1;
      o_data_side_flag_out <= 1'b0;
      dload_r <= 1'b0;
    end else begin
      o_reg_rdata <= i_reg_read ? rd_mux : 32'h0000_0000;
      o_reg_ack <= (i_reg_read || i_reg_write) && (ihit || dhit);
      // write port carries the init address and the word being filled
      o_instr_ram_write_addr <= instr_init_address_r;
      o_instr_ram_write_data <= wr_fill ? i_reg_wdata : instr_fill_data_r;
      o_odd_word_write_en <= wr_fill && instr_init_address_r[0];
      o_even_word_write_en <= wr_fill && !instr_init_address_r[0];
      if (ifetch_hit)
        o_instr_ram_read_addr <= i_fetch_addr[`OCM_IADDR_HI:`OCM_IADDR_LO];
      o_instr_ram_read_en <= ilaunch;
      o_fetch_claim <= ifetch_hit;
      o_fetch_valid <= idone;
      if (idone) o_fetch_data <= i_instr_ram_read_data;
      o_data_claim <= ddec_hit;
      if (ddec_hit) begin
        dload_r <= i_load_req;
        o_data_ram_addr <= i_data_addr[`OCM_DADDR_HI:`OCM_DADDR_LO];
      end
      o_data_is_load <= dload_r;
      o_data_valid <= ddone;
      o_load_use_latency <= data_side_control_r[`OCM_CTL_FWD] ? 2'h2 : 2'h1;
      o_data_side_flag_out <= data_side_control_r[`OCM_CTL_BUSY];
    end
  end
  // unused data launch only paces the sequencer
  wire unused_dlaunch = dlaunch;
  property p_fill_one_hot;
    @(posedge i_clk) disable iff (i_reset)
      wr_fill |=> (o_odd_word_write_en ^ o_even_word_write_en);
  endproperty
  a_fill_one_hot: assert property (p_fill_one_hot) else $error("fill enable not one-hot");
  property p_init_inc;
    @(posedge i_clk) disable iff (i_reset || reset_d_r)
      (wr_fill && !wr_init) |=> instr_init_address_r == $past(instr_init_address_r) + 21'h1;
  endproperty
  a_init_inc: assert property (p_init_inc) else $error("init address not incremented");
  property p_fill_data;
    @(posedge i_clk) disable iff (i_reset)
      wr_fill |=> o_instr_ram_write_data == $past(i_reg_wdata);
  endproperty
  a_fill_data: assert property (p_fill_data) else $error("fill data wrong");
  property p_no_decode;
    @(posedge i_clk) disable iff (i_reset)
      !ien |=> !o_fetch_claim;
  endproperty
  a_no_decode: assert property (p_no_decode) else $error("claim while disabled");
  property p_busy;
    @(posedge i_clk) disable iff (i_reset)
      ##1 o_data_side_flag_out == $past(data_side_control_r[`OCM_CTL_BUSY]);
  endproperty
  a_busy: assert property (p_busy) else $error("busy mismatch");
  property p_fwd;
    @(posedge i_clk) disable iff (i_reset)
      data_side_control_r[`OCM_CTL_FWD] |=> o_load_use_latency == 2'h2;
  endproperty
  a_fwd: assert property (p_fwd) else $error("latency wrong");
  property p_load_first;
    @(posedge i_clk) disable iff (i_reset)
      (ddec_hit && i_load_req && i_store_req) |=> dload_r;
  endproperty
  a_load_first: assert property (p_load_first) else $error("store beat load");
  property p_tie_load;
    @(posedge i_clk) disable iff (i_reset)
      // sampled reset keeps the last reset edge out of the antecedent
      (reset_d_r && !i_reset) |=>
        instr_side_control_r == $past(i_instr_control_init_tie);
  endproperty
  a_tie_load: assert property (p_tie_load) else $error("tie not loaded");
endmodule : ocm_ctrl

// File: ocm_ram_model.sv
// instruction block ram model facing the controller
`timescale 1ns/10ps
module ocm_ram_model (
  input wire logic i_clk,
  input wire logic [20:0] i_read_addr,
  input wire logic i_read_en,
  input wire logic [20:0] i_write_addr,
  input wire logic [31:0] i_write_data,
  input wire logic i_odd_en,
  input wire logic i_even_en,
  output logic [63:0] o_read_data
);
  logic [63:0] mem_r [64];
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem_r[i] = {32'hB000_0000 | 32'(i), 32'hA000_0000 | 32'(i)};
    end
    o_read_data = 64'h0;
  end
  // output holds between reads, as a real block ram does
  always @(posedge i_clk) begin
    if (i_read_en) begin
      o_read_data <= mem_r[i_read_addr[5:0]];
    end
    if (i_even_en) begin
      mem_r[i_write_addr[5:0]][31:0] <= i_write_data;
    end
    if (i_odd_en) begin
      mem_r[i_write_addr[5:0]][63:32] <= i_write_data;
    end
  end
endmodule : ocm_ram_model

// File: testbench.sv
// self-checking bench for the on-chip memory controller
`timescale 1ns/10ps
module testbench;
  logic i_clk, i_reset, i_reg_read, i_reg_write, o_reg_ack, i_fetch_req;
  logic o_fetch_claim, o_fetch_valid, i_load_req, i_store_req;
  logic o_data_claim, o_data_is_load, o_data_valid, o_data_side_flag_out;
  logic o_instr_ram_read_en, o_odd_word_write_en, o_even_word_write_en;
  logic [7:0] i_data_regbus_base_tie, i_instr_regbus_base_tie;
  logic [7:0] i_data_range_init_tie, i_data_control_init_tie;
  logic [7:0] i_instr_range_init_tie, i_instr_control_init_tie;
  logic [9:0] i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, i_fetch_addr, i_data_addr;
  logic [31:0] o_instr_ram_write_data;
  logic [63:0] o_fetch_data, i_instr_ram_read_data;
  logic [1:0] o_load_use_latency;
  logic [21:0] o_data_ram_addr;
  logic [20:0] o_instr_ram_read_addr, o_instr_ram_write_addr;
  int num_errors = 0;
  int check_count = 0;

  ocm_ctrl dut (.*);
  ocm_ram_model ram (
    .i_clk(i_clk),
    .i_read_addr(o_instr_ram_read_addr),
    .i_read_en(o_instr_ram_read_en),
    .i_write_addr(o_instr_ram_write_addr),
    .i_write_data(o_instr_ram_write_data),
    .i_odd_en(o_odd_word_write_en),
    .i_even_en(o_even_word_write_en),
    .o_read_data(i_instr_ram_read_data)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic do_reset;
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
  endtask : do_reset

  // writes expect zero read data, the bus only drives it on reads
  task automatic reg_acc(input logic [9:0] a, input logic wr,
      input logic [31:0] d, input logic ack, input logic [31:0] exp);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_write <= wr;
    i_reg_read <= ~wr;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_write <= 1'b0;
    i_reg_read <= 1'b0;
    #1;
    cmp(o_reg_ack, ack);
    cmp(o_reg_rdata, exp);
  endtask : reg_acc

  // lat counts edges after the taking edge until valid; 9 means never
  task automatic fetch(input logic [31:0] a, input logic cl, input int lat,
      input logic [63:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    i_fetch_addr <= a;
    i_fetch_req <= 1'b1;
    @(posedge i_clk);
    i_fetch_req <= 1'b0;
    #1;
    cmp(o_fetch_claim, cl);
    while (k < 9 && o_fetch_valid !== 1'b1) begin
      @(posedge i_clk);
      #1;
      k++;
      if (o_instr_ram_read_en === 1'b1) begin
        cmp({cl, o_instr_ram_read_addr}, {1'b1, a[23:3]});
      end
    end
    cmp(64'(k), 64'(lat));
    if (cl) begin
      cmp(o_fetch_data, d);
    end
  endtask : fetch

  task automatic dacc(input logic [31:0] a, input logic ld, input logic st,
      input logic cl, input logic isl, input int lat);
    int k;
    k = 0;
    @(posedge i_clk);
    i_data_addr <= a;
    i_load_req <= ld;
    i_store_req <= st;
    @(posedge i_clk);
    i_load_req <= 1'b0;
    i_store_req <= 1'b0;
    #1;
    cmp(o_data_claim, cl);
    while (k < 9 && o_data_valid !== 1'b1) begin
      @(posedge i_clk);
      #1;
      k++;
      // load-wins flag trails the claim by one cycle
      if (k == 1) begin
        cmp(o_data_is_load, isl);
      end
      if (k == 1 && cl) begin
        cmp(o_data_ram_addr, a[23:2]);
      end
    end
    cmp(64'(k), 64'(lat));
  endtask : dacc

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    reg_acc(10'h01E, 1'b0, 32'h0, 1'b1, 32'hF4);
    reg_acc(10'h01F, 1'b0, 32'h0, 1'b1, 32'h80);
    reg_acc(10'h01C, 1'b0, 32'h0, 1'b1, 32'h0);
    reg_acc(10'h02E, 1'b0, 32'h0, 1'b1, 32'hFF);
    reg_acc(10'h02F, 1'b0, 32'h0, 1'b1, 32'h80);
    reg_acc(10'h02C, 1'b0, 32'h0, 1'b1, 32'h0);
    reg_acc(10'h3FE, 1'b0, 32'h0, 1'b0, 32'h0);
  endtask : t_regs

  task automatic t_fill;
    reg_acc(10'h02C, 1'b1, 32'h4, 1'b1, 32'h0);
    reg_acc(10'h02D, 1'b1, 32'h1234_5678, 1'b1, 32'h0);
    cmp({o_even_word_write_en, o_odd_word_write_en}, 2'b10);
    cmp(o_instr_ram_write_addr, 21'h4);
    cmp(o_instr_ram_write_data, 32'h1234_5678);
    @(posedge i_clk);
    #1;
    cmp({o_even_word_write_en, o_odd_word_write_en,
        o_instr_ram_write_addr}, {2'b00, 21'h5});
    reg_acc(10'h02D, 1'b1, 32'h9ABC_DEF0, 1'b1, 32'h0);
    cmp({o_even_word_write_en, o_odd_word_write_en,
        o_instr_ram_write_addr}, {2'b01, 21'h5});
    reg_acc(10'h02C, 1'b0, 32'h0, 1'b1, 32'h6);
    reg_acc(10'h02D, 1'b0, 32'h0, 1'b1, 32'h9ABC_DEF0);
  endtask : t_fill

  task automatic t_fetch;
    fetch(32'hFF00_0020, 1'b1, 3, {32'hB000_0004, 32'h1234_5678});
    fetch(32'hFF00_0028, 1'b1, 3, {32'h9ABC_DEF0, 32'hA000_0005});
    fetch(32'hFE00_0020, 1'b0, 9, 64'h0);
    reg_acc(10'h02F, 1'b1, 32'h82, 1'b1, 32'h0);
    fetch(32'hFF00_0030, 1'b1, 6, {32'hB000_0006, 32'hA000_0006});
    reg_acc(10'h02F, 1'b1, 32'h00, 1'b1, 32'h0);
    fetch(32'hFF00_0020, 1'b0, 9, 64'h0);
    reg_acc(10'h02F, 1'b1, 32'h80, 1'b1, 32'h0);
    reg_acc(10'h02E, 1'b1, 32'h12, 1'b1, 32'h0);
    fetch(32'h1200_0038, 1'b1, 3, {32'hB000_0007, 32'hA000_0007});
  endtask : t_fetch

  task automatic t_data;
    dacc(32'hF400_0104, 1'b1, 1'b1, 1'b1, 1'b1, 3);
    dacc(32'hF4FF_FFF8, 1'b0, 1'b1, 1'b1, 1'b0, 3);
    dacc(32'hF500_0000, 1'b1, 1'b0, 1'b0, 1'b0, 9);
    cmp({o_data_side_flag_out, o_load_use_latency}, 3'b001);
    reg_acc(10'h01F, 1'b1, 32'hB0, 1'b1, 32'h0);
    @(posedge i_clk);
    #1;
    cmp({o_data_side_flag_out, o_load_use_latency}, 3'b110);
    reg_acc(10'h01F, 1'b1, 32'h81, 1'b1, 32'h0);
    dacc(32'hF400_0010, 1'b1, 1'b0, 1'b1, 1'b1, 5);
    reg_acc(10'h01E, 1'b1, 32'h11, 1'b1, 32'h0);
    reg_acc(10'h01E, 1'b0, 32'h0, 1'b1, 32'h11);
  endtask : t_data

  task automatic t_rereset;
    i_instr_range_init_tie <= 8'h34;
    do_reset();
    reg_acc(10'h02E, 1'b0, 32'h0, 1'b1, 32'h34);
    reg_acc(10'h01E, 1'b0, 32'h0, 1'b1, 32'hF4);
    reg_acc(10'h01F, 1'b0, 32'h0, 1'b1, 32'h80);
    reg_acc(10'h02D, 1'b0, 32'h0, 1'b1, 32'h0);
  endtask : t_rereset

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic results;
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  initial begin
    repeat (3000) @(posedge i_clk);
    num_errors++;
    results();
  end

  initial begin
    i_reset = 1'b1;
    {i_reg_read, i_reg_write, i_fetch_req, i_load_req, i_store_req} = 5'h0;
    i_reg_addr = 10'h0;
    {i_reg_wdata, i_fetch_addr, i_data_addr} = 96'h0;
    i_data_regbus_base_tie = 8'h07;
    i_instr_regbus_base_tie = 8'h0B;
    i_data_range_init_tie = 8'hF4;
    i_data_control_init_tie = 8'h80;
    i_instr_range_init_tie = 8'hFF;
    i_instr_control_init_tie = 8'h80;
    do_reset();
    t_regs();
    t_fill();
    t_fetch();
    t_data();
    t_rereset();
    results();
  end
endmodule : testbench
